// file: monitor_consts.svh
// Register offsets, field positions and reset values of the alert mask and enable block.
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CFG_OFFSET 8'h00
`define AME_OFFSET 8'h06

// ----------------------------------------------------------------------------
// Field positions of the mask and enable register
// ----------------------------------------------------------------------------
`define LIMIT_EN_MSB 15
`define LIMIT_EN_LSB 11
`define CONV_DONE_EN_BIT 10
`define RSVD_MSB 9
`define RSVD_LSB 6
`define MEM_ERR_BIT 5
`define LIMIT_FLAG_BIT 4
`define CONV_FLAG_BIT 3
`define OVF_FLAG_BIT 2
`define LEVEL_INV_BIT 1
`define HOLD_MODE_BIT 0

// ----------------------------------------------------------------------------
// Configuration register operating mode field
// ----------------------------------------------------------------------------
`define CFG_MODE_MSB 2
`define CFG_MODE_LSB 0
`define CFG_MODE_POWER_DOWN 3'h4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AME_RESET 16'h0000
`define LIMIT_EN_RESET 5'h00

`endif

// file: monitor_pkg.sv
// Types shared by the alert mask and enable block and its limit comparator.
`default_nettype none

package monitor_pkg;

    // Results of the last completed conversion cycle.
    typedef struct packed {
        logic [15:0] shunt_value;
        logic [15:0] bus_value;
        logic [15:0] power_value;
    } results_t;

    // Status flags held by the block.
    typedef struct packed {
        logic memory_integrity_error;
        logic limit_source_flag;
        logic conv_done_flag;
        logic math_overflow_flag;
    } flags_t;

    // One-hot limit selection, highest priority in the top bit.
    typedef struct packed {
        logic shunt_over_alert_en;
        logic shunt_under_alert_en;
        logic bus_over_alert_en;
        logic bus_under_alert_en;
        logic power_over_alert_en;
    } limit_en_t;

endpackage

`default_nettype wire

// file: limit_compare.sv
// Compares the selected conversion result against the alert threshold.
`timescale 1ns/1ns
`default_nettype none

module limit_compare #(
    parameter int WIDTH = 16
) (
    input wire monitor_pkg::limit_en_t limit_en,
    input wire monitor_pkg::results_t results,
    input wire logic [WIDTH-1:0] threshold,
    output logic hit
);

    // ------------------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------------------
    logic shunt_over;
    logic shunt_under;
    logic bus_over;
    logic bus_under;
    logic power_over;

    // Shunt results are two's complement, bus and power results unsigned.
    always_comb begin
        shunt_over = $signed(results.shunt_value) > $signed(threshold);
        shunt_under = $signed(results.shunt_value) < $signed(threshold);
        bus_over = results.bus_value > threshold;
        bus_under = results.bus_value < threshold;
        power_over = results.power_value > threshold;
    end

    // The enables are one-hot, so an OR of the gated terms picks the selected one.
    always_comb begin
        hit = (limit_en.shunt_over_alert_en & shunt_over)
            | (limit_en.shunt_under_alert_en & shunt_under)
            | (limit_en.bus_over_alert_en & bus_over)
            | (limit_en.bus_under_alert_en & bus_under)
            | (limit_en.power_over_alert_en & power_over);
    end

endmodule

`default_nettype wire

// file: monitor_alert_mask_enable.sv
// Alert mask and enable register with limit alerting and status flags of a power monitor.
`timescale 1ns/1ns
`default_nettype none

`include "monitor_consts.svh"

// Operation
// - Shunt-over enable alerts when shunt exceeds threshold.
// - Shunt-under enable alerts when shunt below threshold.
// - Bus-over enable alerts when bus exceeds threshold.
// - Bus-under enable alerts when bus below threshold.
// - Power-over enable alerts when power exceeds threshold.
// - Only highest-priority limit enable can become set.
// - Conversion-ready enable routes ready flag onto alert.
// - Conversion-ready alert combines with selected limit.
// - Limit flag set when limit causes alert.
// - Latched mode: limit flag clears on register read.
// - Transparent: limit flag clears after clean conversion.
// - Ready flag set after whole cycle completes.
// - Ready flag clears on mask read or non-power-down config write.
// - Overflow flag set on arithmetic overflow.
// - Polarity bit: low open-drain or inverted high.
// - Transparent: alert idles once fault is gone.
// - Latched: alert holds until register is read.
// - Hold mode bit selects latched; resets zero.
// - Selected result compared against sixteen-bit threshold.
module monitor_alert_mask_enable #(
    parameter int DATA_WIDTH = 16,
    parameter int ADDR_WIDTH = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ADDR_WIDTH-1:0] REG_ADDR,
    input wire logic [DATA_WIDTH-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_WIDTH-1:0] REG_RDATA,
    input wire logic CONV_DONE,
    input wire monitor_pkg::results_t RESULTS,
    input wire logic [DATA_WIDTH-1:0] LIMIT_VALUE,
    input wire logic MATH_OVF,
    input wire logic MEM_ERR,
    output logic ALERT_O,
    output logic ALERT_OE
);

    // ------------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------------
    logic ame_read;
    logic ame_write;
    logic cfg_write;
    logic cfg_clears_ready;

    always_comb begin
        ame_read = REG_RD && (REG_ADDR == `AME_OFFSET);
        ame_write = REG_WR && (REG_ADDR == `AME_OFFSET);
        cfg_write = REG_WR && (REG_ADDR == `CFG_OFFSET);
        cfg_clears_ready = cfg_write
            && (REG_WDATA[`CFG_MODE_MSB:`CFG_MODE_LSB] != `CFG_MODE_POWER_DOWN);
    end

    // ------------------------------------------------------------------------
    // Limit enable priority filter
    // ------------------------------------------------------------------------
    localparam int NUM_LIMITS = `LIMIT_EN_MSB - `LIMIT_EN_LSB + 1;

    logic [NUM_LIMITS-1:0] limit_en_wr;
    logic [NUM_LIMITS-1:0] limit_en_kept;

    assign limit_en_wr = REG_WDATA[`LIMIT_EN_MSB:`LIMIT_EN_LSB];

    // A lower enable survives a write only when no higher one is written with it.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_prio
            if (gi == NUM_LIMITS - 1) begin : g_top
                assign limit_en_kept[gi] = limit_en_wr[gi];
            end else begin : g_low
                assign limit_en_kept[gi] = limit_en_wr[gi]
                    & ~(|limit_en_wr[NUM_LIMITS-1:gi+1]);
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Writable control bits
    // ------------------------------------------------------------------------
    monitor_pkg::limit_en_t limit_en_q;
    logic conv_done_alert_en_q;
    logic alert_level_invert_q;
    logic alert_hold_mode_q;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            limit_en_q <= `LIMIT_EN_RESET;
        end else if (ame_write) begin
            limit_en_q <= limit_en_kept;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            conv_done_alert_en_q <= 1'b0;
        end else if (ame_write) begin
            conv_done_alert_en_q <= REG_WDATA[`CONV_DONE_EN_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alert_level_invert_q <= 1'b0;
        end else if (ame_write) begin
            alert_level_invert_q <= REG_WDATA[`LEVEL_INV_BIT];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alert_hold_mode_q <= 1'b0;
        end else if (ame_write) begin
            alert_hold_mode_q <= REG_WDATA[`HOLD_MODE_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------------------
    logic limit_hit;

    // The threshold and the result chosen by the enables meet here.
    limit_compare #(
        .WIDTH(DATA_WIDTH)
    ) u_limit_compare (
        .limit_en(limit_en_q),
        .results(RESULTS),
        .threshold(LIMIT_VALUE),
        .hit(limit_hit)
    );

    // ------------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------------
    monitor_pkg::flags_t flags_q;
    logic limit_source_flag_d;
    logic conv_done_flag_d;

    // The limit is judged once per completed conversion cycle.
    always_comb begin
        limit_source_flag_d = flags_q.limit_source_flag;
        if (alert_hold_mode_q) begin
            if (CONV_DONE && limit_hit) begin
                limit_source_flag_d = 1'b1;
            end else if (ame_read) begin
                limit_source_flag_d = 1'b0;
            end
        end else if (CONV_DONE) begin
            limit_source_flag_d = limit_hit;
        end
    end

    // A completion in the same cycle as a clearing access keeps the flag set.
    always_comb begin
        conv_done_flag_d = flags_q.conv_done_flag;
        if (CONV_DONE) begin
            conv_done_flag_d = 1'b1;
        end else if (ame_read || cfg_clears_ready) begin
            conv_done_flag_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags_q.limit_source_flag <= 1'b0;
        end else begin
            flags_q.limit_source_flag <= limit_source_flag_d;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags_q.conv_done_flag <= 1'b0;
        end else begin
            flags_q.conv_done_flag <= conv_done_flag_d;
        end
    end

    // Overflow stays set until the register is read; a new overflow wins.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags_q.math_overflow_flag <= 1'b0;
        end else if (MATH_OVF) begin
            flags_q.math_overflow_flag <= 1'b1;
        end else if (ame_read) begin
            flags_q.math_overflow_flag <= 1'b0;
        end
    end

    // An integrity error is sticky and no access clears it.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags_q.memory_integrity_error <= 1'b0;
        end else if (MEM_ERR) begin
            flags_q.memory_integrity_error <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------------
    logic [DATA_WIDTH-1:0] ame_word;

    always_comb begin
        ame_word = `AME_RESET;
        ame_word[`LIMIT_EN_MSB:`LIMIT_EN_LSB] = limit_en_q;
        ame_word[`CONV_DONE_EN_BIT] = conv_done_alert_en_q;
        ame_word[`RSVD_MSB:`RSVD_LSB] = 4'h0;
        ame_word[`MEM_ERR_BIT] = flags_q.memory_integrity_error;
        ame_word[`LIMIT_FLAG_BIT] = flags_q.limit_source_flag;
        ame_word[`CONV_FLAG_BIT] = flags_q.conv_done_flag;
        ame_word[`OVF_FLAG_BIT] = flags_q.math_overflow_flag;
        ame_word[`LEVEL_INV_BIT] = alert_level_invert_q;
        ame_word[`HOLD_MODE_BIT] = alert_hold_mode_q;
    end

    // Reads are never held off by the ready flag; the word shows pre-clear state.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= `AME_RESET;
        end else if (REG_RD) begin
            REG_RDATA <= ame_read ? ame_word : `AME_RESET;
        end
    end

    // ------------------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------------------
    logic alert_active;

    // The ready flag reaches the pin only when its enable is set.
    always_comb begin
        alert_active = limit_source_flag_d
            | (conv_done_alert_en_q & conv_done_flag_d);
    end

    // Open drain: normal pulls low while active, inverted pulls low while idle.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ALERT_OE <= 1'b0;
        end else begin
            ALERT_OE <= alert_level_invert_q ? ~alert_active : alert_active;
        end
    end

    // The pin is only ever driven low.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ALERT_O <= 1'b0;
        end else begin
            ALERT_O <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: monitor_ame_chk_sva.sv
// Port-level checker of the alert mask and enable block.
`timescale 1ns/1ns
`default_nettype none
`include "monitor_consts.svh"
module monitor_ame_chk (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic CONV_DONE,
    input wire logic MATH_OVF,
    input wire logic MEM_ERR,
    input wire logic ALERT_OE
);
    logic ev;
    assign ev = CONV_DONE | REG_WR | REG_RD;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    sequence s_mask_rd;
        REG_RD && REG_ADDR == `AME_OFFSET;
    endsequence
    sequence s_idle;
        !REG_RD && !REG_WR;
    endsequence
    sequence s_quiet;
        !CONV_DONE && !MATH_OVF;
    endsequence
    property p_rsvd;
        REG_RD |=> REG_RDATA[9:6] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_unmapped;
        REG_RD && REG_ADDR != `AME_OFFSET |=> REG_RDATA == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_onehot;
        s_mask_rd |=> $onehot0(REG_RDATA[15:11]);
    endproperty
    a_onehot: assert property (p_onehot) else $error("several limits enabled");
    property p_conv;
        CONV_DONE ##1 s_idle ##1 s_mask_rd |=> REG_RDATA[3];
    endproperty
    a_conv: assert property (p_conv) else $error("ready flag missing");
    property p_ovf;
        MATH_OVF ##1 s_idle ##1 s_mask_rd |=> REG_RDATA[2];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing");
    property p_mem;
        MEM_ERR ##1 s_idle ##1 s_mask_rd |=> REG_RDATA[5];
    endproperty
    a_mem: assert property (p_mem) else $error("memory error flag missing");
    property p_clear;
        (REG_RD && REG_ADDR == `AME_OFFSET && !CONV_DONE && !MATH_OVF) ##1 s_quiet
            ##1 s_mask_rd |=> REG_RDATA[3:2] == 2'b00;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared by read");
    property p_oe;
        $changed(ALERT_OE) |-> $past(ev) || $past(ev, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("alert moved without cause");
    property p_hold;
        !REG_RD |=> $stable(REG_RDATA);
    endproperty
    a_hold: assert property (p_hold) else $error("read data changed");
endmodule
bind monitor_alert_mask_enable monitor_ame_chk monitor_ame_chk_i (.MCLK(MCLK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CONV_DONE(CONV_DONE), .MATH_OVF(MATH_OVF), .MEM_ERR(MEM_ERR), .ALERT_OE(ALERT_OE));
`default_nettype wire

// file: host_model.sv
// Host that reaches the mask and enable register and watches the alert pin.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic alert_o,
    input wire logic alert_oe,
    output logic pin
);
    // The pin has a pull-up, so a released driver reads high.
    assign pin = alert_oe ? alert_o : 1'b1;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Each access holds its strobe for one clock; a write then drives inverted data.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: monitor_alert_mask_enable_test.sv
// Self-checking testbench of the alert mask and enable block.
`timescale 1ns/1ns
`default_nettype none
`include "monitor_consts.svh"
module monitor_alert_mask_enable_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic conv_done = 1'b0;
    logic math_ovf = 1'b0;
    logic mem_err = 1'b0;
    logic [15:0] limit_value = 16'h0100;
    monitor_pkg::results_t results = '0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, alert_o, alert_oe, pin;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    monitor_alert_mask_enable monitor_alert_mask_enable_i (.MCLK(mclk), .RST(rst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .CONV_DONE(conv_done), .RESULTS(results),
        .LIMIT_VALUE(limit_value), .MATH_OVF(math_ovf), .MEM_ERR(mem_err),
        .ALERT_O(alert_o), .ALERT_OE(alert_oe));
    host_model host_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_o(alert_o),
        .alert_oe(alert_oe), .pin(pin));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pin_is(input logic e);
        check({15'h0000, pin}, {15'h0000, e});
    endtask
    task automatic rd_mask(input logic [15:0] e);
        host_model_i.rd(`AME_OFFSET, d);
        check(d, e);
    endtask
    task automatic wr(input logic [15:0] v);
        host_model_i.wr(`AME_OFFSET, v);
        host_model_i.rd(`AME_OFFSET, d);
    endtask
    task automatic conv(input logic [15:0] v);
        @(posedge mclk);
        #1;
        conv_done = 1'b1;
        results = {v, v, v};
        @(posedge mclk);
        #1;
        conv_done = 1'b0;
    endtask
    task automatic t_limits;
        logic [15:0] hv[5] = '{16'h0200, 16'h8300, 16'h0200, 16'h0080, 16'h0200};
        logic [15:0] mv[5] = '{16'h8300, 16'h0200, 16'h0080, 16'h0200, 16'h0080};
        logic [15:0] en;
        for (int i = 0; i < 5; i++) begin
            en = 16'h8000 >> i;
            wr(en);
            conv(hv[i]);
            pin_is(1'b0);
            rd_mask(en | 16'h0018);
            conv(mv[i]);
            pin_is(1'b1);
            rd_mask(en | 16'h0008);
        end
        $display("t_limits done");
    endtask
    task automatic t_regs;
        host_model_i.wr(`AME_OFFSET, 16'hFBFF);
        rd_mask(16'h8003);
        host_model_i.wr(`AME_OFFSET, 16'h1800);
        rd_mask(16'h1000);
        host_model_i.rd(8'h07, d);
        check(d, 16'h0000);
        $display("t_regs done");
    endtask
    task automatic t_latched;
        wr(16'h8001);
        conv(16'h0200);
        conv(16'h0080);
        pin_is(1'b0);
        rd_mask(16'h8019);
        pin_is(1'b1);
        rd_mask(16'h8001);
        $display("t_latched done");
    endtask
    task automatic t_ready;
        wr(16'h0400);
        conv(16'h0000);
        pin_is(1'b0);
        host_model_i.wr(`CFG_OFFSET, {13'h0000, `CFG_MODE_POWER_DOWN});
        pin_is(1'b0);
        host_model_i.wr(`CFG_OFFSET, 16'h0007);
        pin_is(1'b1);
        wr(16'h8400);
        conv(16'h0200);
        rd_mask(16'h8418);
        pin_is(1'b0);
        wr(16'h8000);
        conv(16'h0080);
        pin_is(1'b1);
        wr(16'h0002);
        pin_is(1'b0);
        wr(16'h0402);
        conv(16'h0000);
        pin_is(1'b1);
        $display("t_ready done");
    endtask
    task automatic t_flags;
        wr(16'h0000);
        math_ovf = 1'b1;
        mem_err = 1'b1;
        @(posedge mclk);
        #1;
        math_ovf = 1'b0;
        mem_err = 1'b0;
        rd_mask(16'h0024);
        rd_mask(16'h0020);
        $display("t_flags done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        rd_mask(`AME_RESET);
        pin_is(1'b1);
        t_limits;
        t_regs;
        t_latched;
        t_ready;
        t_flags;
        report_and_stop;
    end
endmodule
`default_nettype wire
